// ==== dsi_map.svh ====
`ifndef DSI_MAP_SVH
`define DSI_MAP_SVH

// timing, in microseconds and clock rate in MHz
`define DSI_CLK_MHZ       200
`define DSI_TOL_US        10000
`define DSI_FILT_US       100000
`define DSI_TP_PER_US     10000000
`define DSI_TP_LEN_US     1000
`define DSI_TP_MISS_MAX   3'h5

// register byte offsets
`define DSI_OFF_CFG_TO    8'h00
`define DSI_OFF_CFG_BR    8'h04
`define DSI_OFF_TOL_TO    8'h08
`define DSI_OFF_TOL_BR    8'h0C
`define DSI_OFF_FILT_TO   8'h10
`define DSI_OFF_FILT_BR   8'h14
`define DSI_OFF_TP_PER    8'h18
`define DSI_OFF_TP_LEN    8'h1C
`define DSI_OFF_CTRL      8'h20
`define DSI_OFF_STATUS    8'h24

// assignment register: [4:0] function, [5] antivalent
`define DSI_CFG_ANTI_BIT  5
`define DSI_CFG_TO_RST    6'h01
`define DSI_CFG_BR_RST    6'h02

// control register fields
`define DSI_CTRL_COUPLE   0
`define DSI_CTRL_BMEAS    1
`define DSI_CTRL_TPCHK_TO 2
`define DSI_CTRL_TPCHK_BR 3
`define DSI_CTRL_FBSEL    4
`define DSI_CTRL_FBIDX    8
`define DSI_CTRL_RST      32'h0000_0002

// status register fields
`define DSI_ST_DERR       0
`define DSI_ST_TPERR      2
`define DSI_ST_FS         4
`define DSI_ST_LEVEL      5
`define DSI_ST_INDEX      8

`endif

// ==== dsi_pkg.sv ====
package dsi_pkg;

    typedef enum logic [4:0] {
        FN_NONE      = 5'h00,
        FN_TORQUE    = 5'h01,
        FN_BRAKE     = 5'h02,
        FN_STOP1     = 5'h03,
        FN_STOP2     = 5'h04,
        FN_OPSTOP    = 5'h05,
        FN_LIMSPEED  = 5'h06,
        FN_LIMPOS    = 5'h07,
        FN_REFSET    = 5'h08,
        FN_INC_ACT   = 5'h09,
        FN_INC_NEXT  = 5'h0A,
        FN_DIR_FWD   = 5'h0B,
        FN_DIR_REV   = 5'h0C,
        FN_SPEEDMON  = 5'h0D,
        FN_ACCEL     = 5'h0E,
        FN_FS_RESET  = 5'h0F,
        FN_SUB0      = 5'h10,
        FN_SUB1      = 5'h11,
        FN_SUB2      = 5'h12
    } dsi_func_t;

    typedef struct packed {
        logic ch_one;
        logic ch_two;
    } dsi_pair_t;

    typedef struct packed {
        logic torque_off_function;
        logic brake_control_function;
        logic stop_one_function;
        logic stop_two_function;
        logic operating_stop_function;
        logic limited_speed_function;
        logic limited_position_function;
        logic reference_capture;
        logic limited_increment_function;
        logic increment_next_step;
        logic safe_direction_forward;
        logic safe_direction_reverse;
        logic speed_monitor_function;
        logic acceleration_limit_function;
    } dsi_req_t;

    typedef struct packed {
        logic [1:0][5:0]        cfg;
        logic [1:0][31:0]       tol;
        logic [1:0][31:0]       filt;
        logic [31:0]            tp_per;
        logic [31:0]            tp_len;
        logic [31:0]            ctrl;
        logic [31:0]            prdata;
        logic                   pslverr;
        logic [1:0][1:0]        stable;
        logic [1:0][1:0][31:0]  fcnt;
        logic [1:0][31:0]       dcnt;
        logic [1:0][31:0]       pw;
        logic [31:0]            tpcnt;
        logic [1:0]             derr;
        logic [1:0]             tperr;
        logic [1:0]             seen;
        logic [1:0][2:0]        miss;
        logic [1:0]             prev_act;
        logic                   fail_safe;
        dsi_req_t               req;
        logic [3:0]             param_index;
    } dsi_state_t;

endpackage

// ==== dsi_eval.sv ====
`include "dsi_map.svh"

module dsi_eval #(
    parameter logic [31:0] TOL_CYCLES    =
        32'(`DSI_TOL_US * `DSI_CLK_MHZ),
    parameter logic [31:0] FILT_CYCLES   =
        32'(`DSI_FILT_US * `DSI_CLK_MHZ),
    parameter logic [31:0] TP_PER_CYCLES =
        32'(64'(`DSI_TP_PER_US) * 64'(`DSI_CLK_MHZ)),
    parameter logic [31:0] TP_LEN_CYCLES =
        32'(`DSI_TP_LEN_US * `DSI_CLK_MHZ)
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  dsi_pkg::dsi_pair_t     torque_off_inputs,
    input  dsi_pkg::dsi_pair_t     brake_control_inputs,
    input  wire logic              safety_error,
    input  wire logic              fieldbus_index_load,
    input  wire logic [2:0]        fieldbus_index,
    output dsi_pkg::dsi_req_t      func_request,
    output logic                   fail_safe,
    output logic [3:0]             param_index,
    output logic                   brake_current_meas_en,
    output logic [1:0]             disc_error,
    output logic [1:0]             test_pulse_error
);

    dsi_pkg::dsi_state_t s;
    dsi_pkg::dsi_state_t next_s;

    logic [1:0][1:0] raw;
    logic [1:0]      tpchk;

    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        return (v == 32'hFFFF_FFFF) ? v : v + 32'h1;
    endfunction

    function automatic logic addr_hit(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `DSI_OFF_STATUS);
    endfunction

    function automatic logic mismatch(input logic anti,
                                      input logic [1:0] p);
        return anti ? (p[1] == p[0]) : (p[1] != p[0]);
    endfunction

    assign raw[0] = {torque_off_inputs.ch_one,
                     torque_off_inputs.ch_two};
    assign raw[1] = {brake_control_inputs.ch_one,
                     brake_control_inputs.ch_two};
    assign tpchk  = {s.ctrl[`DSI_CTRL_TPCHK_BR],
                     s.ctrl[`DSI_CTRL_TPCHK_TO]};

    always_comb begin
        logic [1:0]     mism;
        logic [1:0]     fault;
        logic [1:0]     act;
        logic [1:0]     on;
        logic [2:0]     sub;
        logic [2:0]     idx;
        logic           inc_block;
        logic           fs_clear;
        logic           period_end;
        logic [1:0]     inv;
        dsi_pkg::dsi_func_t f;
        dsi_pkg::dsi_req_t  r;
        next_s     = s;
        mism       = '0;
        fault      = '0;
        act        = '0;
        on         = '0;
        sub        = '0;
        idx        = '0;
        inc_block  = 1'b0;
        fs_clear   = 1'b0;
        inv        = '0;
        f          = dsi_pkg::FN_NONE;
        r          = '0;
        period_end = (s.tpcnt >= s.tp_per);

        // apb setup phase samples read data for the access phase
        if (psel && !penable) begin
            next_s.pslverr = !addr_hit(paddr);
            unique case (paddr)
                `DSI_OFF_CFG_TO:  next_s.prdata = {26'h0, s.cfg[0]};
                `DSI_OFF_CFG_BR:  next_s.prdata = {26'h0, s.cfg[1]};
                `DSI_OFF_TOL_TO:  next_s.prdata = s.tol[0];
                `DSI_OFF_TOL_BR:  next_s.prdata = s.tol[1];
                `DSI_OFF_FILT_TO: next_s.prdata = s.filt[0];
                `DSI_OFF_FILT_BR: next_s.prdata = s.filt[1];
                `DSI_OFF_TP_PER:  next_s.prdata = s.tp_per;
                `DSI_OFF_TP_LEN:  next_s.prdata = s.tp_len;
                `DSI_OFF_CTRL:    next_s.prdata = s.ctrl;
                `DSI_OFF_STATUS: begin
                    next_s.prdata = 32'h0;
                    next_s.prdata[`DSI_ST_DERR +: 2]  = s.derr;
                    next_s.prdata[`DSI_ST_TPERR +: 2] = s.tperr;
                    next_s.prdata[`DSI_ST_FS]         = s.fail_safe;
                    next_s.prdata[`DSI_ST_LEVEL +: 2] =
                        {s.stable[1][1], s.stable[0][1]};
                    next_s.prdata[`DSI_ST_INDEX +: 4] = s.param_index;
                end
                default:          next_s.prdata = 32'h0;
            endcase
        end

        // apb write, taken in the access phase
        if (psel && penable && pwrite) begin
            unique case (paddr)
                `DSI_OFF_CFG_TO:  next_s.cfg[0]  = pwdata[5:0];
                `DSI_OFF_CFG_BR:  next_s.cfg[1]  = pwdata[5:0];
                `DSI_OFF_TOL_TO:  next_s.tol[0]  = pwdata;
                `DSI_OFF_TOL_BR:  next_s.tol[1]  = pwdata;
                `DSI_OFF_FILT_TO: next_s.filt[0] = pwdata;
                `DSI_OFF_FILT_BR: next_s.filt[1] = pwdata;
                `DSI_OFF_TP_PER:  next_s.tp_per  = pwdata;
                `DSI_OFF_TP_LEN:  next_s.tp_len  = pwdata;
                `DSI_OFF_CTRL:    next_s.ctrl    = pwdata;
                `DSI_OFF_STATUS: begin
                    // write one to clear; hardware set below wins
                    next_s.derr  = s.derr & ~pwdata[`DSI_ST_DERR +: 2];
                    next_s.tperr = s.tperr & ~pwdata[`DSI_ST_TPERR +: 2];
                    if (pwdata[`DSI_ST_FS]) begin
                        next_s.fail_safe = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // fieldbus index change overrides the input bits
        if (fieldbus_index_load) begin
            next_s.ctrl[`DSI_CTRL_FBIDX +: 3] = fieldbus_index;
            next_s.ctrl[`DSI_CTRL_FBSEL]      = 1'b1;
        end

        // shared test-pulse period counter
        next_s.tpcnt = period_end ? 32'h0 : sat_inc(s.tpcnt);

        for (int i = 0; i < 2; i++) begin
            // per-channel filter: change accepted after filter time
            for (int c = 0; c < 2; c++) begin
                if (raw[i][c] != s.stable[i][c]) begin
                    if (s.fcnt[i][c] >= s.filt[i]) begin
                        next_s.stable[i][c] = raw[i][c];
                        next_s.fcnt[i][c]   = 32'h0;
                    end else begin
                        next_s.fcnt[i][c] = sat_inc(s.fcnt[i][c]);
                    end
                end else begin
                    next_s.fcnt[i][c] = 32'h0;
                end
            end

            // discrepancy timer, restarts at each new mismatch
            mism[i] = mismatch(s.cfg[i][`DSI_CFG_ANTI_BIT],
                               s.stable[i]);
            next_s.dcnt[i] = mism[i] ? sat_inc(s.dcnt[i])
                                     : 32'h0;
            if (mism[i] && (s.dcnt[i] >= s.tol[i])) begin
                next_s.derr[i] = 1'b1;
            end

            // test pulses: short inversions of channel one
            inv[i] = (raw[i][1] != s.stable[i][1]);
            if (tpchk[i]) begin
                next_s.pw[i] = inv[i] ? sat_inc(s.pw[i]) : 32'h0;
                if (!inv[i] && (s.pw[i] != 32'h0)
                    && (s.pw[i] <= s.tp_len)) begin
                    next_s.seen[i] = 1'b1;
                end
                if (inv[i] && (raw[i][0] != s.stable[i][0])) begin
                    next_s.tperr[i] = 1'b1;  // pulse on both channels
                end
                if (period_end) begin
                    next_s.seen[i] = 1'b0;
                    if (s.seen[i]) begin
                        next_s.miss[i] = 3'h0;
                    end else if (s.miss[i] < `DSI_TP_MISS_MAX) begin
                        next_s.miss[i] = s.miss[i] + 3'h1;
                    end
                end
                if (s.miss[i] >= `DSI_TP_MISS_MAX) begin
                    next_s.tperr[i] = 1'b1;
                end
            end else begin
                next_s.pw[i]   = 32'h0;
                next_s.seen[i] = 1'b0;
                next_s.miss[i] = 3'h0;
            end

            // demand on channel one at 0V or on any fault
            fault[i] = s.derr[i] | s.tperr[i];
            act[i]   = !s.stable[i][1] || fault[i];
            on[i]    = !act[i];
            next_s.prev_act[i] = act[i];

            f = dsi_pkg::dsi_func_t'(s.cfg[i][4:0]);
            unique case (f)
                dsi_pkg::FN_TORQUE:
                    r.torque_off_function |= act[i];
                dsi_pkg::FN_BRAKE:
                    r.brake_control_function |= act[i];
                dsi_pkg::FN_STOP1:
                    r.stop_one_function |= act[i];
                dsi_pkg::FN_STOP2:
                    r.stop_two_function |= act[i];
                dsi_pkg::FN_OPSTOP:
                    r.operating_stop_function |= act[i];
                dsi_pkg::FN_LIMSPEED:
                    r.limited_speed_function |= act[i];
                dsi_pkg::FN_LIMPOS:
                    r.limited_position_function |= act[i];
                dsi_pkg::FN_REFSET:
                    r.reference_capture |=
                        act[i] & !s.prev_act[i];
                dsi_pkg::FN_INC_ACT:
                    inc_block |= on[i];
                dsi_pkg::FN_INC_NEXT:
                    r.increment_next_step |= on[i];
                dsi_pkg::FN_DIR_FWD:
                    r.safe_direction_forward |= act[i];
                dsi_pkg::FN_DIR_REV:
                    r.safe_direction_reverse |= act[i];
                dsi_pkg::FN_SPEEDMON:
                    r.speed_monitor_function |= act[i];
                dsi_pkg::FN_ACCEL:
                    r.acceleration_limit_function |= act[i];
                dsi_pkg::FN_FS_RESET:
                    fs_clear |= !s.stable[i][1];
                dsi_pkg::FN_SUB0:
                    sub[0] |= on[i];
                dsi_pkg::FN_SUB1:
                    sub[1] |= on[i];
                dsi_pkg::FN_SUB2:
                    sub[2] |= on[i];
                default: ;
            endcase
        end

        r.limited_increment_function = !inc_block;
        if (s.ctrl[`DSI_CTRL_COUPLE]) begin
            r.brake_control_function |= r.torque_off_function;
        end
        next_s.req = r;

        // fail-safe bit: the error set wins over any clear
        if (fs_clear) begin
            next_s.fail_safe = 1'b0;
        end
        if (safety_error) begin
            next_s.fail_safe = 1'b1;
        end

        idx = s.ctrl[`DSI_CTRL_FBSEL] ? s.ctrl[`DSI_CTRL_FBIDX +: 3]
                                      : sub;
        next_s.param_index = {1'b0, idx} + 4'h1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s         <= '0;
            s.cfg[0]  <= `DSI_CFG_TO_RST;
            s.cfg[1]  <= `DSI_CFG_BR_RST;
            s.tol[0]  <= TOL_CYCLES;
            s.tol[1]  <= TOL_CYCLES;
            s.filt[0] <= FILT_CYCLES;
            s.filt[1] <= FILT_CYCLES;
            s.tp_per  <= TP_PER_CYCLES;
            s.tp_len  <= TP_LEN_CYCLES;
            s.ctrl    <= `DSI_CTRL_RST;
            s.param_index <= 4'h1;
        end else begin
            s <= next_s;
        end
    end

    assign pready                = psel & penable;
    assign prdata                = s.prdata;
    assign pslverr               = s.pslverr & psel & penable;
    assign func_request          = s.req;
    assign fail_safe             = s.fail_safe;
    assign param_index           = s.param_index;
    assign brake_current_meas_en = s.ctrl[`DSI_CTRL_BMEAS];
    assign disc_error            = s.derr;
    assign test_pulse_error      = s.tperr;

endmodule

// ==== dsi_contacts.sv ====
// two-channel contacts; channel two may lag channel one
module dsi_contacts (
    input  wire logic          clk,
    input  dsi_pkg::dsi_pair_t want_to,
    input  dsi_pkg::dsi_pair_t want_br,
    input  wire logic [4:0]    skew,
    output dsi_pkg::dsi_pair_t torque_off_inputs,
    output dsi_pkg::dsi_pair_t brake_control_inputs
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] h_to = '0;
    logic [31:0] h_br = '0;

    always_ff @(posedge clk) begin
        h_to <= {h_to[30:0], want_to.ch_two};
        h_br <= {h_br[30:0], want_br.ch_two};
    end

    // contacts drive 24V or 0V and emit no test pulses
    assign torque_off_inputs.ch_one = want_to.ch_one;
    assign brake_control_inputs.ch_one = want_br.ch_one;
    assign torque_off_inputs.ch_two =
        (skew == 5'h00) ? want_to.ch_two : h_to[skew - 5'h01];
    assign brake_control_inputs.ch_two =
        (skew == 5'h00) ? want_br.ch_two : h_br[skew - 5'h01];
endmodule

// ==== dsi_eval_asserts.sv ====
`include "dsi_map.svh"

module dsi_eval_asserts #(
    parameter logic [31:0] FILT_CYCLES = 32'h0000_0004
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [7:0]   paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    input  wire logic [31:0]  prdata,
    input  wire logic         pready,
    input  wire logic         pslverr,
    input  dsi_pkg::dsi_pair_t torque_off_inputs,
    input  wire logic         safety_error,
    input  wire logic         fieldbus_index_load,
    input  dsi_pkg::dsi_req_t func_request,
    input  wire logic         fail_safe,
    input  wire logic [3:0]   param_index,
    input  wire logic         brake_current_meas_en,
    input  wire logic [1:0]   disc_error,
    input  wire logic [1:0]   test_pulse_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic        acc_wr;
    logic        st_wr;
    logic        hold_hi;
    logic [4:0]  cfg_to;
    logic [4:0]  cfg_br;
    logic [31:0] hi_cnt;

    assign acc_wr = psel && penable && pwrite && pready;
    assign st_wr = acc_wr && paddr == `DSI_OFF_STATUS;
    assign hold_hi = torque_off_inputs.ch_one && !disc_error[0]
        && cfg_to == dsi_pkg::FN_TORQUE && cfg_br != dsi_pkg::FN_TORQUE
        && !test_pulse_error[0];

    // shadow of both assignment registers and a count of steady 24V cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_to <= 5'h01;
            cfg_br <= 5'h02;
            hi_cnt <= 32'h0;
        end else begin
            if (acc_wr && paddr == `DSI_OFF_CFG_TO) cfg_to <= pwdata[4:0];
            if (acc_wr && paddr == `DSI_OFF_CFG_BR) cfg_br <= pwdata[4:0];
            hi_cnt <= hold_hi ? hi_cnt + 32'h1 : 32'h0;
        end
    end

    property p_pready;
        pready == (psel && penable);
    endproperty
    a_pready: assert property (p_pready)
        else $error("pready does not follow psel and penable");

    property p_refused;
        psel && penable && (paddr > 8'h24 || paddr[1:0] != 2'h0)
            |-> pslverr && prdata == 32'h0;
    endproperty
    a_refused: assert property (p_refused)
        else $error("unmapped access not refused");

    property p_reset_vals;
        $fell(srst) |-> param_index == 4'h1 && brake_current_meas_en
            && !fail_safe && disc_error == 2'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong output values after reset");

    property p_fs_set;
        safety_error |=> fail_safe;
    endproperty
    a_fs_set: assert property (p_fs_set)
        else $error("fail-safe bit not set by an error");

    property p_fs_clear;
        $fell(fail_safe) |-> $past(st_wr && pwdata[4])
            || $past(cfg_to == dsi_pkg::FN_FS_RESET)
            || $past(cfg_br == dsi_pkg::FN_FS_RESET);
    endproperty
    a_fs_clear: assert property (p_fs_clear)
        else $error("fail-safe bit cleared without a cause");

    property p_disc_sticky;
        disc_error[0] && !(st_wr && pwdata[0]) |=> disc_error[0];
    endproperty
    a_disc_sticky: assert property (p_disc_sticky)
        else $error("discrepancy error dropped by itself");

    property p_none;
        (cfg_to == 5'h00 && cfg_br == 5'h00) [*2] |->
            !func_request.torque_off_function
            && !func_request.brake_control_function
            && func_request.limited_increment_function;
    endproperty
    a_none: assert property (p_none)
        else $error("unassigned inputs changed the requests");

    property p_torque_held;
        hi_cnt > FILT_CYCLES + 32'h2 |-> !func_request.torque_off_function;
    endproperty
    a_torque_held: assert property (p_torque_held)
        else $error("torque off demanded with channel one at 24V");

    property p_refcap;
        func_request.reference_capture |=> !func_request.reference_capture;
    endproperty
    a_refcap: assert property (p_refcap)
        else $error("reference capture longer than one cycle");

    property p_meas;
        acc_wr && paddr == `DSI_OFF_CTRL
            |=> brake_current_meas_en == $past(pwdata[1]);
    endproperty
    a_meas: assert property (p_meas)
        else $error("brake current switch does not follow its write");

    c_disc: cover property ($rose(disc_error[0]));
    c_fs: cover property ($fell(fail_safe));
    c_fb: cover property (fieldbus_index_load ##2 param_index == 4'h8);
endmodule

bind dsi_eval dsi_eval_asserts #(
    .FILT_CYCLES(FILT_CYCLES)
) u_dsi_eval_asserts (
    .clk                  (clk),
    .srst                 (srst),
    .paddr                (paddr),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .torque_off_inputs    (torque_off_inputs),
    .safety_error         (safety_error),
    .fieldbus_index_load  (fieldbus_index_load),
    .func_request         (func_request),
    .fail_safe            (fail_safe),
    .param_index          (param_index),
    .brake_current_meas_en(brake_current_meas_en),
    .disc_error           (disc_error),
    .test_pulse_error     (test_pulse_error)
);

// ==== dsi_eval_tb.sv ====
`include "dsi_map.svh"

module dsi_eval_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int FILT = 4;
    localparam int TOL = 8;

    logic               clk = 1'b0;
    logic               srst, psel, penable, pwrite, rerr;
    logic               safety_error, fieldbus_index_load;
    logic               pready, pslverr, fail_safe, meas_en;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rdat;
    logic [2:0]         fieldbus_index;
    logic [4:0]         skew;
    logic [3:0]         param_index;
    logic [1:0]         disc_error, tp_error;
    dsi_pkg::dsi_pair_t want_to, want_br, to_in, br_in;
    dsi_pkg::dsi_req_t  req;
    int                 miscompares = 0;
    int                 comparisons = 0;

    always #2.5 clk = ~clk;

    dsi_contacts u_dsi_contacts (.clk(clk), .want_to(want_to),
        .want_br(want_br), .skew(skew), .torque_off_inputs(to_in),
        .brake_control_inputs(br_in));

    dsi_eval #(.TOL_CYCLES(32'(TOL)), .FILT_CYCLES(32'(FILT)),
        .TP_PER_CYCLES(32'd200), .TP_LEN_CYCLES(32'd4)) u_dsi_eval (
        .clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .torque_off_inputs(to_in), .brake_control_inputs(br_in),
        .safety_error(safety_error),
        .fieldbus_index_load(fieldbus_index_load),
        .fieldbus_index(fieldbus_index), .func_request(req),
        .fail_safe(fail_safe), .param_index(param_index),
        .brake_current_meas_en(meas_en), .disc_error(disc_error),
        .test_pulse_error(tp_error));

    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) miscompares++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic drive(input logic [1:0] t, input logic [1:0] b,
                         input logic [4:0] sk);
        want_to <= t;
        want_br <= b;
        skew <= sk;
    endtask

    function automatic logic [13:0] exp_req(input int c, input logic hi);
        logic [13:0] r;
        r = 14'h0020;
        if ((c >= 1 && c <= 7) || (c >= 11 && c <= 14)) r[14 - c] = !hi;
        if (c == 9) r[5] = !hi;
        if (c == 10) r[4] = hi;
        return r;
    endfunction

    task automatic t_reset;
        check(32'(req.torque_off_function), 32'h1);
        apb(`DSI_OFF_CFG_TO, 1'b0, 32'h0);
        check(rdat, 32'h1);
        apb(`DSI_OFF_TOL_TO, 1'b0, 32'h0);
        check(rdat, 32'(TOL));
        apb(`DSI_OFF_CTRL, 1'b0, 32'h0);
        check(rdat, 32'h2);
        check(32'(param_index), 32'h1);
        apb(8'h28, 1'b0, 32'h0);
        check(32'(rerr), 32'h1);
        apb(8'h02, 1'b0, 32'h0);
        check(32'(rerr), 32'h1);
    endtask

    task automatic t_funcs;
        logic [3:0] idx;
        wr(`DSI_OFF_CFG_BR, 32'h0);
        for (int c = 0; c <= 18; c++) begin
            wr(`DSI_OFF_CFG_TO, 32'(c));
            for (int h = 0; h < 2; h++) begin
                drive(h ? 2'b11 : 2'b00, 2'b00, 5'h00);
                cyc(FILT + 4);
                idx = 4'h1 + ((c >= 16 && h == 1) ? 4'(1 << (c - 16)) : 4'h0);
                check(32'(req), 32'(exp_req(c, h[0])));
                check(32'(param_index), 32'(idx));
            end
        end
        wr(`DSI_OFF_CFG_TO, 32'h1);
        wr(`DSI_OFF_CFG_BR, 32'h2);
        drive(2'b11, 2'b11, 5'h00);
        cyc(FILT + 4);
        check(32'(req[13:12]), 32'h0);
        apb(`DSI_OFF_STATUS, 1'b0, 32'h0);
        check(32'(rdat[6:5]), 32'h3);
    endtask

    task automatic t_disc;
        drive(2'b00, 2'b11, 5'h05);
        cyc(FILT + 20);
        check(32'(disc_error), 32'h0);
        drive(2'b11, 2'b11, 5'h14);
        cyc(FILT + TOL - 2);
        check(32'(disc_error), 32'h0);
        cyc(TOL + 6);
        check(32'(disc_error), 32'h1);
        check(32'(req.torque_off_function), 32'h1);
        cyc(20);
        wr(`DSI_OFF_STATUS, 32'h3);
        check(32'(disc_error), 32'h0);
    endtask

    task automatic t_anti;
        wr(`DSI_OFF_CFG_TO, 32'h21);
        drive(2'b10, 2'b11, 5'h00);
        cyc(FILT + 4);
        wr(`DSI_OFF_STATUS, 32'h3);
        cyc(FILT + TOL + 4);
        check(32'(disc_error), 32'h0);
        check(32'(req.torque_off_function), 32'h0);
        drive(2'b11, 2'b11, 5'h00);
        cyc(FILT + TOL + 6);
        check(32'(disc_error), 32'h1);
        wr(`DSI_OFF_CFG_TO, 32'h1);
        cyc(FILT + 4);
        wr(`DSI_OFF_STATUS, 32'h3);
    endtask

    task automatic t_failsafe;
        wr(`DSI_OFF_CFG_BR, 32'(dsi_pkg::FN_FS_RESET));
        safety_error <= 1'b1;
        @(posedge clk);
        safety_error <= 1'b0;
        cyc(10);
        check(32'(fail_safe), 32'h1);
        drive(2'b00, 2'b00, 5'h00);
        cyc(FILT + 4);
        check(32'(fail_safe), 32'h0);
        wr(`DSI_OFF_CTRL, 32'h1);
        check(32'(meas_en), 32'h0);
        cyc(1);
        check(32'(req.brake_control_function), 32'h1);
        wr(`DSI_OFF_CTRL, 32'h2);
        check(32'(meas_en), 32'h1);
    endtask

    task automatic t_index;
        wr(`DSI_OFF_CFG_TO, 32'(dsi_pkg::FN_SUB0));
        wr(`DSI_OFF_CFG_BR, 32'(dsi_pkg::FN_SUB2));
        drive(2'b11, 2'b11, 5'h00);
        cyc(FILT + 4);
        check(32'(param_index), 32'h6);
        fieldbus_index <= 3'h7;
        fieldbus_index_load <= 1'b1;
        @(posedge clk);
        fieldbus_index_load <= 1'b0;
        cyc(3);
        check(32'(param_index), 32'h8);
        wr(`DSI_OFF_CTRL, 32'h6);
        cyc(1100);
        check(32'(tp_error), 32'h1);
    endtask

    initial begin
        srst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        safety_error <= 1'b0;
        fieldbus_index_load <= 1'b0;
        fieldbus_index <= 3'h0;
        drive(2'b00, 2'b00, 5'h00);
        cyc(10);
        srst <= 1'b0;
        cyc(3);
        t_reset();
        t_funcs();
        t_disc();
        t_anti();
        t_failsafe();
        t_index();
        finish_test();
    end

    initial begin
        cyc(20000);
        miscompares++;
        finish_test();
    end
endmodule
